//--- rtl/repeater_pkg.sv
// Notes on behaviour
// - Transmit received data or alternating preamble/jam.
// - Decode Manchester line bits to retimed NRZ.
// - Hold data bits in 64-bit FIFO.
// - Send alternating jam during any collision.
// - Extend short packets with jam to 96.
// - Stop transmitting after 65536 bits, jabber lock.
// - Pick source port from port carrier status.
// - Start preamble soon after source identified.
// - Write real data only after SFD.
// - Fill FIFO with 1011 before SFD.
// - Read FIFO after 60 preamble bits sent.
// - Timers enforce repeater quiet intervals.
// - Expansion data is NRZ with status lines.
// - Carrier plus grant, no collision: drive link.
// - No carrier, grant, no collision: receive link.
// - Jam flag: data 1 single, 0 multiport.
// - Integrator merges carriers, returns grant and collision.
// - Each end runs its own clock; asynchronous.
// - Receiver samples on incoming clock rising edge.
// - Driver changes data away from rising edge.
package repeater_pkg;
  localparam int PORT_COUNT = 9;
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W      = 6;
  localparam int CNT_W      = 7;
  localparam logic [CNT_W-1:0] FIFO_FULL = 7'h40;
  localparam int BITCNT_W   = 17;
  localparam int JABBER_BITS = 65536;
  localparam logic [BITCNT_W-1:0] MIN_FRAME_BITS = 17'h00060;
  localparam logic [BITCNT_W-1:0] PREAMBLE_BITS  = 17'h0003C;
  localparam logic [3:0] FILL_PATTERN = 4'hB;
  localparam logic [7:0] SFD_PATTERN  = 8'hAB;
  // Quiet times in bit periods after a packet and after a collision
  localparam int QUIET_W = 8;
  localparam logic [QUIET_W-1:0] REPEATER_INTERVAL_ONE_BITS = 8'h60;
  localparam logic [QUIET_W-1:0] REPEATER_INTERVAL_SIX_BITS = 8'h60;
  // Bit timing from the core clock by phase accumulation
  localparam int CORE_CLK_MHZ = 125;
  localparam int LINK_BIT_MHZ = 10;
  localparam int ACC_W = 7;
  localparam logic [ACC_W:0] ACC_STEP = 8'(LINK_BIT_MHZ);
  localparam logic [ACC_W:0] ACC_MOD  = 8'(CORE_CLK_MHZ);
  localparam logic [ACC_W:0] ACC_HALF = 8'(CORE_CLK_MHZ / 2);
  // Manchester blanking after a mid-bit edge, a least time
  localparam int BLANK_NS = 75;
  localparam logic [3:0] BLANK_CYC = 4'((BLANK_NS * CORE_CLK_MHZ + 999) / 1000);

  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_PREAMBLE = 6'h02,
    ST_DATA     = 6'h04,
    ST_JAM      = 6'h08,
    ST_EXTEND   = 6'h10,
    ST_QUIET    = 6'h20
  } rep_state_t;

  function automatic logic accWrap(input logic [ACC_W-1:0] a);
    accWrap = ({1'b0, a} + ACC_STEP) >= ACC_MOD;
  endfunction

  function automatic logic accHalf(input logic [ACC_W-1:0] a);
    accHalf = ({1'b0, a} < ACC_HALF) && (({1'b0, a} + ACC_STEP) >= ACC_HALF);
  endfunction

  function automatic logic [ACC_W-1:0] accNext(input logic [ACC_W-1:0] a);
    logic [ACC_W:0] s;
    s = {1'b0, a} + ACC_STEP;
    if (s >= ACC_MOD) begin
      s = s - ACC_MOD;
    end
    accNext = s[ACC_W-1:0];
  endfunction
endpackage

//--- rtl/expansion_if.sv
`timescale 1ns/1ps
interface expansion_if;
  logic expansionCarrierSense;
  logic expansionBusEnable;
  logic expansionCollision;
  logic devData;
  logic devDataOe;
  logic devClock;
  logic devClockOe;
  logic devJam;
  logic devJamOe;
  logic intData;
  logic intDataOe;
  logic intClock;
  logic intClockOe;
  logic intJam;
  logic intJamOe;
  logic expansionData;
  logic expansionClock;
  logic expansionJamFlag;

  // Shared lines resolved from enables; an undriven line reads low
  assign expansionData    = devDataOe  ? devData  : (intDataOe  ? intData  : 1'b0);
  assign expansionClock   = devClockOe ? devClock : (intClockOe ? intClock : 1'b0);
  assign expansionJamFlag = devJamOe   ? devJam   : (intJamOe   ? intJam   : 1'b0);

  modport device (
    output expansionCarrierSense, devData, devDataOe, devClock, devClockOe, devJam, devJamOe,
    input  expansionBusEnable, expansionCollision, expansionData, expansionClock, expansionJamFlag
  );
  modport integrator (
    input  expansionCarrierSense, expansionData, expansionClock, expansionJamFlag,
    output expansionBusEnable, expansionCollision, intData, intDataOe, intClock, intClockOe, intJam, intJamOe
  );
endinterface

//--- rtl/repeater_kernel.sv
`timescale 1ns/1ps
module repeater_kernel
  import repeater_pkg::*;
#(
  parameter int PORTS        = PORT_COUNT,
  parameter int JABBER_LIMIT = JABBER_BITS
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  expansion_if.device           exp,
  input  wire logic [PORTS-1:0] portCarrier,
  input  wire logic [PORTS-1:0] portCollision,
  input  wire logic [PORTS-1:0] portLine,
  output logic                  repeatData,
  output logic                  repeatStrobe,
  output logic                  repeatActive,
  output logic                  jabberLocked
);
  localparam int IDX_W = $clog2(PORTS);
  localparam logic [BITCNT_W-1:0] JAB_LIM = BITCNT_W'(JABBER_LIMIT);

  function automatic logic [IDX_W-1:0] firstSet(input logic [PORTS-1:0] v);
    firstSet = '0;
    for (int i = PORTS - 1; i >= 0; i--)
      if (v[i]) firstSet = IDX_W'(i);
  endfunction

  logic [PORTS-1:0]    carS1_r, carS2_r, colS1_r, colS2_r, lineS1_r, lineS2_r;
  logic                benS1_r, benS2_r, icolS1_r, icolS2_r;
  logic                xclkS1_r, xclkS2_r, xclkD_r;
  logic                linkBit_r, linkJam_r;
  rep_state_t          state_r, goState;
  logic [IDX_W-1:0]    srcIdx_r;
  logic                srcExp_r;
  logic [BITCNT_W-1:0] bitCnt_r;
  logic [QUIET_W-1:0]  quietCnt_r;
  logic                jamPh_r, lock_r, txBit_r, txOn_r, strobe_r, crs_r;
  logic [ACC_W-1:0]    acc_r;
  logic                lineD_r;
  logic [3:0]          blankCnt_r;
  logic [7:0]          rxShift_r;
  logic                sfdSeen_r;
  logic [1:0]          fillPh_r;
  logic                fifoMem [FIFO_DEPTH];
  logic [PTR_W-1:0]    wrPtr_r, rdPtr_r;
  logic [CNT_W-1:0]    fill_r;
  logic                xRxJam_r, xData_r, xClk_r, xJam_r, xOe_r;
  logic                emitPat, emitFifo, endPkt;

  // capture data and jam flag on the incoming rising edge; no reset, as the clock stops between frames
  always_ff @(posedge exp.expansionClock) begin
    linkBit_r <= exp.expansionData;
    linkJam_r <= exp.expansionJamFlag;
  end

  // every foreign level passes two flops, including the link clock seen as a rising edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      carS1_r  <= '0;
      carS2_r  <= '0;
      colS1_r  <= '0;
      colS2_r  <= '0;
      lineS1_r <= '0;
      lineS2_r <= '0;
      benS1_r  <= 1'b0;
      benS2_r  <= 1'b0;
      icolS1_r <= 1'b0;
      icolS2_r <= 1'b0;
      xclkS1_r <= 1'b0;
      xclkS2_r <= 1'b0;
      xclkD_r  <= 1'b0;
    end else begin
      carS1_r  <= portCarrier;
      carS2_r  <= carS1_r;
      colS1_r  <= portCollision;
      colS2_r  <= colS1_r;
      lineS1_r <= portLine;
      lineS2_r <= lineS1_r;
      benS1_r  <= exp.expansionBusEnable;
      benS2_r  <= benS1_r;
      icolS1_r <= exp.expansionCollision;
      icolS2_r <= icolS1_r;
      xclkS1_r <= exp.expansionClock;
      xclkS2_r <= xclkS1_r;
      xclkD_r  <= xclkS2_r;
    end
  end

  logic bitTick, halfTick, xEdge, rxMode, txAllowed, srcLine, decValid;
  logic inValid, inBit, srcActive, multiCol, singleCol, collision, wrEn, rdEn, nextBit;
  assign bitTick  = accWrap(acc_r);
  assign halfTick = accHalf(acc_r);
  assign xEdge    = xclkS2_r & ~xclkD_r;
  // receive only when not sensing carrier and granted without collision
  // no grant or a collision blocks both directions
  assign rxMode    = ~crs_r & benS2_r & ~icolS2_r;
  // drive only with own carrier and a clean grant
  assign txAllowed = crs_r & benS2_r & ~icolS2_r;
  assign srcLine   = lineS2_r[srcIdx_r];
  // a transition outside the blanking window is the mid-bit edge
  assign decValid  = (srcLine != lineD_r) && (blankCnt_r == 4'h0);
  assign inValid   = ((state_r == ST_PREAMBLE) || (state_r == ST_DATA)) &&
                     (srcExp_r ? (rxMode && xEdge) : decValid);
  assign inBit     = srcExp_r ? linkBit_r : srcLine;
  assign srcActive = srcExp_r ? rxMode : carS2_r[srcIdx_r];
  assign multiCol  = |(carS2_r & (carS2_r - 1'b1));
  assign singleCol = |colS2_r;
  // any local, integrator or remote collision forces jam
  assign collision = multiCol | singleCol | (benS2_r & icolS2_r) | xRxJam_r | (srcExp_r & (|carS2_r));
  assign wrEn      = inValid && (fill_r != FIFO_FULL);
  assign rdEn      = bitTick && emitFifo;
  // either stored data or the alternating pattern, first bit one
  assign nextBit   = emitFifo ? fifoMem[rdPtr_r] : ~jamPh_r;

  // Free-running bit timebase; retiming to it strips receive jitter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_r <= '0;
    end else begin
      acc_r <= accNext(acc_r);
    end
  end

  // Manchester decoder on the selected port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lineD_r    <= 1'b0;
      blankCnt_r <= 4'h0;
    end else begin
      lineD_r <= srcLine;
      if (decValid) begin
        blankCnt_r <= BLANK_CYC;
      end else if (blankCnt_r != 4'h0) begin
        blankCnt_r <= blankCnt_r - 4'h1;
      end
    end
  end

  // Delimiter search and fill-pattern phase
  always_ff @(posedge core_clk) begin
    if (rst || state_r == ST_IDLE) begin
      rxShift_r <= 8'h00;
      sfdSeen_r <= 1'b0;
      fillPh_r  <= 2'h0;
    end else if (inValid) begin
      rxShift_r <= {rxShift_r[6:0], inBit};
      // real data is stored from the bit after the delimiter
      if ({rxShift_r[6:0], inBit} == SFD_PATTERN) begin
        sfdSeen_r <= 1'b1;
      end
      fillPh_r <= fillPh_r + 2'h1;
    end
  end

  // 64-entry bit store, no reset needed for contents
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      // pattern bits stand in until the delimiter is found
      fifoMem[wrPtr_r] <= sfdSeen_r ? inBit : FILL_PATTERN[2'h3 - fillPh_r];
    end
  end

  // FIFO pointers and level; full drops bits rather than overwrite
  always_ff @(posedge core_clk) begin
    if (rst || state_r == ST_IDLE) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r  <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + PTR_W'(wrEn);
      rdPtr_r <= rdPtr_r + PTR_W'(rdEn);
      fill_r  <= fill_r + CNT_W'(wrEn) - CNT_W'(rdEn);
    end
  end

  // Per-bit decision of the transmitting states
  always_comb begin
    emitPat  = 1'b0;
    emitFifo = 1'b0;
    endPkt   = 1'b0;
    goState  = state_r;
    case (state_r)
      ST_PREAMBLE: begin
        emitPat = 1'b1;
        if (collision) begin
          goState = ST_JAM;
        // stored data follows the sixtieth preamble bit
        end else if (bitCnt_r == PREAMBLE_BITS - 1'b1) begin
          goState = ST_DATA;
        end
      end
      ST_DATA: begin
        if (collision) begin
          emitPat = 1'b1;
          goState = ST_JAM;
        end else if (fill_r != '0) begin
          emitFifo = 1'b1;
        end else if (srcActive) begin
          emitPat = 1'b1;
        // a fragment is padded with pattern up to the minimum
        end else if (bitCnt_r < MIN_FRAME_BITS) begin
          emitPat = 1'b1;
          goState = ST_EXTEND;
        end else begin
          endPkt = 1'b1;
        end
      end
      ST_JAM: begin
        if (collision || srcActive || bitCnt_r < MIN_FRAME_BITS) begin
          emitPat = 1'b1;
        end else begin
          endPkt = 1'b1;
        end
      end
      ST_EXTEND: begin
        if (bitCnt_r < MIN_FRAME_BITS) begin
          emitPat = 1'b1;
        end else begin
          endPkt = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  // Main controller
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      srcIdx_r   <= '0;
      srcExp_r   <= 1'b0;
      bitCnt_r   <= '0;
      quietCnt_r <= '0;
      jamPh_r    <= 1'b0;
      lock_r     <= 1'b0;
      txBit_r    <= 1'b0;
      txOn_r     <= 1'b0;
      strobe_r   <= 1'b0;
    end else begin
      strobe_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          txOn_r   <= 1'b0;
          bitCnt_r <= '0;
          jamPh_r  <= 1'b0;
          // lowest active port wins; expansion only when no local carrier
          // preamble starts on the next bit tick
          if (|carS2_r) begin
            srcIdx_r <= firstSet(carS2_r);
            srcExp_r <= 1'b0;
            state_r  <= ST_PREAMBLE;
          end else if (rxMode && xEdge) begin
            srcExp_r <= 1'b1;
            state_r  <= ST_PREAMBLE;
          end
        end
        ST_QUIET: begin
          txOn_r <= 1'b0;
          // quiet interval counted in bit times before the next packet
          if (bitTick && quietCnt_r != '0) begin
            quietCnt_r <= quietCnt_r - 1'b1;
          end
          if (quietCnt_r == '0 && !(lock_r && srcActive)) begin
            lock_r  <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          if (bitTick) begin
            // lock after the limit; held until the source goes quiet
            if (bitCnt_r == JAB_LIM) begin
              lock_r     <= 1'b1;
              txOn_r     <= 1'b0;
              quietCnt_r <= REPEATER_INTERVAL_SIX_BITS;
              state_r    <= ST_QUIET;
            end else if (endPkt) begin
              txOn_r     <= 1'b0;
              quietCnt_r <= (state_r == ST_JAM) ? REPEATER_INTERVAL_SIX_BITS : REPEATER_INTERVAL_ONE_BITS;
              state_r    <= ST_QUIET;
            end else begin
              txOn_r   <= 1'b1;
              txBit_r  <= nextBit;
              jamPh_r  <= emitPat ? ~jamPh_r : jamPh_r;
              bitCnt_r <= bitCnt_r + 1'b1;
              strobe_r <= 1'b1;
              state_r  <= goState;
            end
          end
        end
      endcase
    end
  end

  // Remote jam flag seen while receiving
  always_ff @(posedge core_clk) begin
    if (rst || !rxMode) begin
      xRxJam_r <= 1'b0;
    end else if (xEdge) begin
      xRxJam_r <= linkJam_r;
    end
  end

  // NRZ out, carrier sense shows a locally sourced packet
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crs_r   <= 1'b0;
      xOe_r   <= 1'b0;
      xClk_r  <= 1'b0;
      xData_r <= 1'b0;
      xJam_r  <= 1'b0;
    end else begin
      crs_r <= (state_r != ST_IDLE) && (state_r != ST_QUIET) && !srcExp_r;
      xOe_r <= txAllowed;
      // data moves on the falling edge, clock rises mid-bit
      if (halfTick) begin
        xClk_r <= 1'b1;
      end else if (bitTick) begin
        xClk_r <= 1'b0;
      end
      if (bitTick) begin
        xJam_r <= multiCol | singleCol;
        // during jam the data line tells single from multiport
        xData_r <= (multiCol | singleCol) ? (singleCol & ~multiCol) : nextBit;
      end
    end
  end

  assign exp.expansionCarrierSense = crs_r;
  assign exp.devData    = xData_r;
  assign exp.devDataOe  = xOe_r;
  assign exp.devClock   = xClk_r;
  assign exp.devClockOe = xOe_r;
  assign exp.devJam     = xJam_r;
  assign exp.devJamOe   = xOe_r;
  assign repeatData   = txBit_r;
  assign repeatStrobe = strobe_r;
  assign repeatActive = txOn_r;
  assign jabberLocked = lock_r;
endmodule

//--- rtl/expansion_integrator.sv
`timescale 1ns/1ps
module expansion_integrator
  import repeater_pkg::*;
#(
  parameter int REMOTES = 3
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  expansion_if.integrator         exp,
  input  wire logic [REMOTES-1:0] remoteCarrier,
  input  wire logic               remoteBit,
  input  wire logic               remoteJam,
  output logic                    remoteTaken,
  output logic                    deviceBit,
  output logic                    deviceJam,
  output logic                    deviceStrobe
);
  logic             crsS1_r, crsS2_r, clkS1_r, clkS2_r, clkD_r, datS1_r, datS2_r, jamS1_r, jamS2_r;
  logic             ben_r, col_r, oe_r, clk_r, dat_r, jam_r, taken_r;
  logic             devBit_r, devJam_r, devStb_r;
  logic [ACC_W-1:0] acc_r;
  logic [REMOTES:0] all;
  logic             anyCrs, multi, drive;

  // device lines come from a foreign clock, two flops each
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crsS1_r <= 1'b0;
      crsS2_r <= 1'b0;
      clkS1_r <= 1'b0;
      clkS2_r <= 1'b0;
      clkD_r  <= 1'b0;
      datS1_r <= 1'b0;
      datS2_r <= 1'b0;
      jamS1_r <= 1'b0;
      jamS2_r <= 1'b0;
    end else begin
      crsS1_r <= exp.expansionCarrierSense;
      crsS2_r <= crsS1_r;
      clkS1_r <= exp.expansionClock;
      clkS2_r <= clkS1_r;
      clkD_r  <= clkS2_r;
      datS1_r <= exp.expansionData;
      datS2_r <= datS1_r;
      jamS1_r <= exp.expansionJamFlag;
      jamS2_r <= jamS1_r;
    end
  end

  // grant when anyone has carrier, collision when two or more do
  assign all    = {remoteCarrier, crsS2_r};
  assign anyCrs = |all;
  assign multi  = |(all & (all - 1'b1));
  // a remote source is forwarded while the device is quiet
  assign drive  = ~crsS2_r & (|remoteCarrier) & ~multi;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ben_r <= 1'b0;
      col_r <= 1'b0;
    end else begin
      ben_r <= anyCrs;
      col_r <= multi;
    end
  end

  // Divided link clock toward the device; data changes on the falling edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_r   <= '0;
      oe_r    <= 1'b0;
      clk_r   <= 1'b0;
      dat_r   <= 1'b0;
      jam_r   <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      acc_r   <= accNext(acc_r);
      oe_r    <= drive;
      taken_r <= 1'b0;
      // rising edge sits mid-bit, away from data changes
      if (accHalf(acc_r)) begin
        clk_r <= 1'b1;
      end else if (accWrap(acc_r)) begin
        clk_r <= 1'b0;
        if (drive) begin
          dat_r   <= remoteBit;
          jam_r   <= remoteJam;
          taken_r <= 1'b1;
        end
      end
    end
  end

  // NRZ bits from a transmitting device, taken at its clock rise
  // accepted only while that device holds the clean grant
  always_ff @(posedge core_clk) begin
    if (rst) begin
      devBit_r <= 1'b0;
      devJam_r <= 1'b0;
      devStb_r <= 1'b0;
    end else begin
      devStb_r <= 1'b0;
      if (crsS2_r && ben_r && !col_r && clkS2_r && !clkD_r) begin
        devBit_r <= datS2_r;
        // jam flag forwarded with its data meaning unchanged
        devJam_r <= jamS2_r;
        devStb_r <= 1'b1;
      end
    end
  end

  assign exp.expansionBusEnable = ben_r;
  assign exp.expansionCollision = col_r;
  assign exp.intData    = dat_r;
  assign exp.intDataOe  = oe_r;
  assign exp.intClock   = clk_r;
  assign exp.intClockOe = oe_r;
  assign exp.intJam     = jam_r;
  assign exp.intJamOe   = oe_r;
  assign remoteTaken  = taken_r;
  assign deviceBit    = devBit_r;
  assign deviceJam    = devJam_r;
  assign deviceStrobe = devStb_r;
endmodule

//--- sim/expansion_assertions.sv
`timescale 1ns/1ps
module expansion_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic expansionCarrierSense,
  input wire logic expansionBusEnable,
  input wire logic expansionCollision,
  input wire logic devData,
  input wire logic devDataOe,
  input wire logic devClock,
  input wire logic devClockOe,
  input wire logic devJamOe,
  input wire logic repeatStrobe,
  input wire logic repeatData,
  input wire logic repeatActive,
  input wire logic jabberLocked
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  no_grant_idle_a: assert property ((!expansionBusEnable || expansionCollision) [*5] |-> !devDataOe)
    else $error("device drives without grant");
  drive_needs_crs_a: assert property (!expansionCarrierSense |=> !devDataOe)
    else $error("device drives without carrier");
  enables_match_a: assert property (devDataOe == devClockOe && devJamOe == devDataOe)
    else $error("link enables differ");
  data_at_fall_a: assert property (devDataOe && $past(devDataOe) && $changed(devData) |-> $fell(devClock))
    else $error("link data moved away from clock fall");
  clock_high_a: assert property ($rose(devClock) && devClockOe |-> ##[5:8] ($fell(devClock) || !devClockOe))
    else $error("link clock high too long");
  clock_low_a: assert property ($fell(devClock) && devClockOe |-> ##[5:8] ($rose(devClock) || !devClockOe))
    else $error("link clock low too long");
  preamble_start_a: assert property ($rose(repeatActive) |-> repeatStrobe && repeatData)
    else $error("transmit did not open with a one");
  bit_spacing_a: assert property (repeatStrobe |=> (!repeatStrobe) [*8])
    else $error("bit ticks too close");
  jabber_quiet_a: assert property (jabberLocked && $past(jabberLocked) |-> !repeatActive)
    else $error("transmit during jabber lock");
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import repeater_pkg::*;
  localparam logic [15:0] TAIL = 16'hAB3C;
  logic       core_clk      = 1'b0;
  logic       intClk        = 1'b0;
  logic       rst           = 1'b1;
  logic [8:0] portCarrier   = 9'h000;
  logic [8:0] portCollision = 9'h000;
  logic [8:0] portLine      = 9'h000;
  logic [2:0] remoteCarrier = 3'h0;
  logic       remoteBit     = 1'b0;
  logic       remoteJam     = 1'b0;
  logic       odd           = 1'b0;
  logic       repeatData, repeatStrobe, repeatActive, jabberLocked;
  logic       remoteTaken, deviceBit, deviceJam, deviceStrobe;
  logic       txq[$], devq[$], jq[$], rmq[$];
  int         num_errors    = 0;
  int         total_checks  = 0;
  int         cycles        = 0;

  expansion_if link();

  // Integrator clock deliberately off the core rate
  always #4 core_clk = ~core_clk;
  always #4.3 intClk = ~intClk;

  repeater_kernel #(.JABBER_LIMIT(200)) u_repeater_kernel (
    .core_clk(core_clk), .rst(rst), .exp(link), .portCarrier(portCarrier),
    .portCollision(portCollision), .portLine(portLine), .repeatData(repeatData),
    .repeatStrobe(repeatStrobe), .repeatActive(repeatActive), .jabberLocked(jabberLocked));
  expansion_integrator u_expansion_integrator (
    .core_clk(intClk), .rst(rst), .exp(link), .remoteCarrier(remoteCarrier),
    .remoteBit(remoteBit), .remoteJam(remoteJam), .remoteTaken(remoteTaken),
    .deviceBit(deviceBit), .deviceJam(deviceJam), .deviceStrobe(deviceStrobe));
  expansion_assertions u_expansion_assertions (
    .core_clk(core_clk), .rst(rst), .expansionCarrierSense(link.expansionCarrierSense),
    .expansionBusEnable(link.expansionBusEnable), .expansionCollision(link.expansionCollision),
    .devData(link.devData), .devDataOe(link.devDataOe), .devClock(link.devClock),
    .devClockOe(link.devClockOe), .devJamOe(link.devJamOe), .repeatStrobe(repeatStrobe),
    .repeatData(repeatData), .repeatActive(repeatActive), .jabberLocked(jabberLocked));

  // Record repeated bits; the cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (repeatStrobe) txq.push_back(repeatData);
    if (cycles == 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  // Bits the integrator took from the device
  always @(posedge intClk) begin
    if (deviceStrobe && deviceJam) jq.push_back(deviceBit);
    else if (deviceStrobe) devq.push_back(deviceBit);
  end

  // Next remote bit after each consumed one
  always @(negedge intClk) begin
    if (remoteTaken && rmq.size() > 0) remoteBit <= rmq.pop_front();
  end

  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR t=%0t seen=%0h want=%0h", $time, seen, want);
    end
  endtask

  // Manchester bit, halves of 6 and 6 or 7 cycles to average 100 ns
  task automatic sendBit(input int p, input logic b);
    portLine[p] = ~b;
    repeat (6) @(negedge core_clk);
    portLine[p] = b;
    odd = ~odd;
    repeat (odd ? 7 : 6) @(negedge core_clk);
  endtask

  task automatic sendFrame(input int p, input int pre);
    portCarrier[p] = 1'b1;
    for (int i = 0; i < pre + 16; i++) sendBit(p, i < pre ? ~i[0] : TAIL[pre + 15 - i]);
    portLine[p] = 1'b0;
    portCarrier[p] = 1'b0;
  endtask

  // Wait out the packet, then the quiet interval
  task automatic waitIdle();
    int n = 0;
    while ((repeatActive === 1'b1 || n < 20) && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    repeat (1300) @(negedge core_clk);
  endtask

  function automatic int findData(input logic q[$]);
    logic [7:0] s = 8'hFF;
    findData = -1;
    for (int i = 0; i < q.size(); i++) begin
      s = {s[6:0], q[i]};
      if (s === 8'h3C && findData < 0) findData = i;
    end
  endfunction

  function automatic logic alt(input logic q[$], input int from, input int upto);
    alt = 1'b1;
    for (int i = from; i < upto; i++) if (q[i] === q[i-1]) alt = 1'b0;
  endfunction

  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    // Short local frame, padded and also sent on the link
    sendFrame(2, 16);
    waitIdle();
    check(txq.size(), 96);
    check(txq[0], 1);
    check({txq[60], txq[61], txq[62], txq[63]}, 4'hB);
    check(alt(txq, 1, 60), 1);
    check(findData(txq) >= 67, 1);
    check(findData(devq) >= 0, 1);
    // Multiport then single-port collision
    for (int m = 0; m < 2; m++) begin
      txq.delete();
      jq.delete();
      fork
        sendFrame(2, 40);
        begin
          repeat (300) @(negedge core_clk);
          if (m == 0) portCarrier[5] = 1'b1;
          else portCollision[2] = 1'b1;
        end
      join
      portCarrier[5] = 1'b0;
      portCollision[2] = 1'b0;
      waitIdle();
      check(alt(txq, 1, txq.size()), 1);
      check(jq.size() > 0, 1);
      foreach (jq[i]) check(jq[i], m[0]);
    end
    // Overlong frame locks the transmitter
    txq.delete();
    sendFrame(2, 240);
    check(jabberLocked, 1);
    waitIdle();
    check(txq.size() <= 200, 1);
    // Frame arriving over the link from a remote device
    txq.delete();
    for (int i = 0; i < 80; i++) rmq.push_back(i < 64 ? ~i[0] : TAIL[79 - i]);
    // Integrator inputs move on its own clock's falling edge
    @(negedge intClk);
    remoteBit = rmq.pop_front();
    remoteCarrier[0] = 1'b1;
    for (int n = 0; n < 3000 && rmq.size() > 0; n++) @(negedge core_clk);
    repeat (40) @(negedge core_clk);
    @(negedge intClk);
    remoteCarrier[0] = 1'b0;
    waitIdle();
    check(findData(txq) >= 0, 1);
    check(alt(txq, 1, 60), 1);
    wrap_up();
  end
endmodule
